/* pwm_pdm_gen.sv */
/*
 * Multi-mode PWM / PDM generator bank with an AHB-Lite register slave.
 * Assumes one 200 MHz clock hclk for bus and pulse logic, a single
 * AHB-Lite master doing single word transfers, and an amplifier on the pins.
 * Pins are registered levels; the amplifier needs no handshake back.
 */
//
// Function
// - An enabled instance drives its disable line inactive and, with a known format code (1 to 4), emits pulses.
// - A disabled instance asserts its disable line and emits no pulses.
// - Each instance owns one active-high disable and two signal outputs whose roles follow the format.
// - Duty is command divided by scale, saturated to the range -1.0 to +1.0.
// - Scale resets to 1.0 so a raw command maps directly to duty.
// - Format 1 is PWM/dir, 2 is up/down, 3 is PDM/dir, 4 is dir/PWM for locked antiphase.
// - The format may be changed while the generator runs.
// - One shared PWM rate in hertz sets the wave period in formats 1, 2 and 4, from 1 Hz up to the top rate.
// - The top PWM and PDM rates follow from the fast clock.
// - A rate set too high is limited to the top supported rate instead of refused.
// - Both shared rates reset to 20000 Hz.
// - In PDM format a pulse-or-space choice is made once per shared slot.
// - Every PDM pulse and space lasts a whole number of slot periods.
// - The PDM slot rate spans about 1525 Hz to just below the fast clock rate.
`timescale 1ns/1ps
`include "pwm_pdm_params.svh"

module pwm_pdm_gen
    import pwm_pdm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output drive_pins_t [`PG_NUM_INST-1:0] pins
);

    // Rate limits and step multiplier, sized to the 32-bit rate words
    localparam int N = `PG_NUM_INST;
    localparam logic [31:0] PWM_MAX = 32'(`PG_PWM_MAX_HZ);
    localparam logic [31:0] PWM_MIN = 32'(`PG_PWM_MIN_HZ);
    localparam logic [31:0] PDM_MAX = 32'(`PG_PDM_MAX_HZ);
    localparam logic [31:0] PDM_MIN = 32'(`PG_PDM_MIN_HZ);
    localparam logic [31:0] STEP_MUL = 32'(`PG_STEP_MUL);

    // Bus data-phase state
    logic dp_write_reg, dp_write_next;
    logic [7:0] dp_addr_reg, dp_addr_next;
    logic [31:0] hrdata_next;

    // Settings
    logic [31:0] pwm_rate_reg, pwm_rate_next;
    logic [31:0] pdm_rate_reg, pdm_rate_next;
    inst_cfg_t [N-1:0] cfg_reg, cfg_next;

    // Shared phase generators
    logic [31:0] pwm_acc_reg, pwm_acc_next;
    logic [31:0] pdm_acc_reg, pdm_acc_next;
    logic pdm_tick_reg, pdm_tick_next;
    logic [31:0] pwm_step, pdm_step;
    logic [63:0] pwm_prod, pdm_prod;

    // Next pin values, one entry per instance, registered in one place
    drive_pins_t pins_nx [N];

    // Limit a written rate into the usable span
    // A zero or tiny rate lands on the minimum, so the wave never stalls
    function automatic logic [31:0] clip_rate(input logic [31:0] v, input logic [31:0] lo,
                                              input logic [31:0] hi);
        logic [31:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end else if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction

    // Address phase capture, register writes and read mux
    always_comb begin
        logic addr_ok;
        logic [31:0] word;
        addr_ok = hsel && htrans[1] && hready;
        dp_write_next = addr_ok && hwrite;
        dp_addr_next = addr_ok ? haddr : dp_addr_reg;
        pwm_rate_next = pwm_rate_reg;
        pdm_rate_next = pdm_rate_reg;
        cfg_next = cfg_reg;
        word = 32'h0;
        // Writes land at the data-phase edge, while hwdata stands
        if (dp_write_reg) begin
            // Rates are clipped on write, never rejected
            if (dp_addr_reg == `PG_OFF_PWM_RATE) begin
                pwm_rate_next = clip_rate(hwdata, PWM_MIN, PWM_MAX);
            end
            if (dp_addr_reg == `PG_OFF_PDM_RATE) begin
                pdm_rate_next = clip_rate(hwdata, PDM_MIN, PDM_MAX);
            end
            // Upper nibble picks the instance block; nibble 0 holds shared settings
            for (int i = 0; i < N; i++) begin
                if (dp_addr_reg[7:4] == 4'(i + 1)) begin
                    unique case (dp_addr_reg[3:2])
                        `PG_IDX_CMD: cfg_next[i].cmd = hwdata;
                        `PG_IDX_SCALE: cfg_next[i].scale = hwdata;
                        // Format taken at any time, even while running
                        `PG_IDX_CTRL: begin
                            cfg_next[i].en = hwdata[`PG_CTRL_EN_BIT];
                            cfg_next[i].fmt = hwdata[`PG_CTRL_FMT_MSB:`PG_CTRL_FMT_LSB];
                        end
                        default: ;
                    endcase
                end
            end
        end

        // Read from next values so a read right after a write sees it
        if (haddr == `PG_OFF_PWM_RATE) begin
            word = pwm_rate_next;
        end else if (haddr == `PG_OFF_PDM_RATE) begin
            word = pdm_rate_next;
        end else if (haddr == `PG_OFF_STATUS) begin
            word = 32'(pins);
        end
        // Unmapped words fall through and read as zero
        for (int i = 0; i < N; i++) begin
            if (haddr[7:4] == 4'(i + 1)) begin
                unique case (haddr[3:2])
                    `PG_IDX_CMD: word = cfg_next[i].cmd;
                    `PG_IDX_SCALE: word = cfg_next[i].scale;
                    `PG_IDX_CTRL: begin
                        word = 32'h0;
                        word[`PG_CTRL_EN_BIT] = cfg_next[i].en;
                        word[`PG_CTRL_FMT_MSB:`PG_CTRL_FMT_LSB] = cfg_next[i].fmt;
                    end
                    default: word = 32'h0;
                endcase
            end
        end
        // Loaded at the address edge, then held until the next read
        hrdata_next = (addr_ok && !hwrite) ? word : hrdata;
    end

    // Bus and settings registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Not ready in reset; ready rises at the first edge after release
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            pwm_rate_reg <= `PG_RATE_DEFAULT_HZ;
            pdm_rate_reg <= `PG_RATE_DEFAULT_HZ;
            for (int i = 0; i < N; i++) begin
                cfg_reg[i].cmd <= 32'h0;
                cfg_reg[i].scale <= `PG_SCALE_ONE;
                cfg_reg[i].fmt <= `PG_FMT_DEFAULT;
                cfg_reg[i].en <= 1'b0;
            end
        end else begin
            dp_write_reg <= dp_write_next;
            dp_addr_reg <= dp_addr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1; // Zero wait states, always OKAY
            hresp <= 1'b0;
            pwm_rate_reg <= pwm_rate_next;
            pdm_rate_reg <= pdm_rate_next;
            cfg_reg <= cfg_next;
        end
    end

    // Rate to phase step; truncation leaves the rate about 0.01 percent slow
    // The PWM phase wraps freely; its top 16 bits are the ramp all instances share
    // The PDM carry out of the adder is the slot tick, one clock wide
    always_comb begin
        pwm_prod = 64'(pwm_rate_reg) * 64'(STEP_MUL);
        pdm_prod = 64'(pdm_rate_reg) * 64'(STEP_MUL);
        pwm_step = pwm_prod[`PG_STEP_SHIFT +: 32];
        pdm_step = pdm_prod[`PG_STEP_SHIFT +: 32];
        pwm_acc_next = pwm_acc_reg + pwm_step;
        {pdm_tick_next, pdm_acc_next} = {1'b0, pdm_acc_reg} + {1'b0, pdm_step};
    end

    // Shared phase accumulators
    // Left running with every instance off; cheap, and phase stays continuous
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_acc_reg <= 32'h0;
            pdm_acc_reg <= 32'h0;
            pdm_tick_reg <= 1'b0;
        end else begin
            pwm_acc_reg <= pwm_acc_next;
            pdm_acc_reg <= pdm_acc_next;
            pdm_tick_reg <= pdm_tick_next;
        end
    end

    // One generator per instance
    for (genvar g = 0; g < N; g++) begin : gen_inst
        // Per-instance delta-sigma error, PDM bit and pin values
        logic [32:0] err_reg, err_next;
        logic pdm_bit_reg, pdm_bit_next;
        drive_pins_t pins_next;
        logic [31:0] mag_v, mag_s, inc;
        logic [47:0] lhs, rhs;
        logic [32:0] sum;
        logic neg, pwm_on, fire;

        // Duty magnitude and sign without a divider
        always_comb begin
            mag_v = cfg_reg[g].cmd[31] ? (~cfg_reg[g].cmd + 32'h1) : cfg_reg[g].cmd;
            mag_s = cfg_reg[g].scale[31] ? (~cfg_reg[g].scale + 32'h1) : cfg_reg[g].scale;
            // Sign of value / scale; zero duty counts as forward
            neg = (cfg_reg[g].cmd[31] ^ cfg_reg[g].scale[31]) && (mag_v != 32'h0);
            // phase * |scale| < |value| <=> phase < duty; saturates at full
            lhs = 48'(pwm_acc_reg[31:16]) * 48'(mag_s);
            rhs = {mag_v, 16'h0};
            pwm_on = lhs < rhs;
            // First-order delta-sigma, increment clipped to |scale|
            inc = (mag_v > mag_s) ? mag_s : mag_v;
            sum = err_reg + 33'(inc);
            // Zero scale with a live command saturates to full density
            fire = (mag_s == 32'h0) ? (mag_v != 32'h0) : ((sum >= 33'(mag_s)) && (inc != 32'h0));
            // Error cleared outside PDM so a later switch starts clean
            err_next = err_reg;
            pdm_bit_next = pdm_bit_reg;
            if (!cfg_reg[g].en || cfg_reg[g].fmt != FMT_PDM_DIR) begin
                err_next = 33'h0;
                pdm_bit_next = 1'b0;
            end else if (pdm_tick_reg) begin
                // Decide once per slot and hold for the whole slot
                err_next = fire ? (sum - 33'(mag_s)) : sum;
                pdm_bit_next = fire;
            end
        end

        // Pin roles by format
        // Direction lines never pulse; only the PWM or PDM line carries duty
        always_comb begin
            pins_next.drv_enable_n = 1'b1;
            pins_next.first_signal_output = 1'b0;
            pins_next.second_signal_output = 1'b0;
            // Disabled is the default, so only an enable turns the driver on, even with an unknown format
            if (cfg_reg[g].en) begin
                pins_next.drv_enable_n = 1'b0;
                unique case (cfg_reg[g].fmt)
                    FMT_PWM_DIR: begin
                        pins_next.first_signal_output = pwm_on;
                        pins_next.second_signal_output = neg;
                    end
                    FMT_UP_DOWN: begin
                        pins_next.first_signal_output = pwm_on && !neg;
                        pins_next.second_signal_output = pwm_on && neg;
                    end
                    FMT_PDM_DIR: begin
                        pins_next.first_signal_output = pdm_bit_reg;
                        pins_next.second_signal_output = neg;
                    end
                    FMT_DIR_PWM: begin
                        pins_next.first_signal_output = neg;
                        pins_next.second_signal_output = pwm_on;
                    end
                    default: ; // Unknown code: driver on, both lines low
                endcase
            end
        end

        // Hand the next pin values to the single pin register
        assign pins_nx[g] = pins_next;

        // Instance state
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                err_reg <= 33'h0;
                pdm_bit_reg <= 1'b0;
            end else begin
                err_reg <= err_next;
                pdm_bit_reg <= pdm_bit_next;
            end
        end
    end

    // Registered drive pins; one process owns the whole output vector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N; i++) begin
                pins[i] <= 3'h4; // Disable asserted, both lines low
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                pins[i] <= pins_nx[i];
            end
        end
    end

endmodule

/* pwm_pdm_params.svh */
/*
 * Constants of the multi-mode pulse generator: register offsets, field
 * positions, reset values and rate limits.
 * Assumes a single 200 MHz bus clock that also serves as the fast clock.
 */
`ifndef PWM_PDM_PARAMS_SVH
`define PWM_PDM_PARAMS_SVH

// Instances and clocking
`define PG_NUM_INST 4
`define PG_CLK_HZ 200000000
// Reference point: a 100 MHz fast clock allows 193 kHz PWM
`define PG_REF_CLK_HZ 100000000
`define PG_REF_PWM_MAX_HZ 193000
`define PG_PWM_MAX_HZ (`PG_REF_PWM_MAX_HZ * (`PG_CLK_HZ / `PG_REF_CLK_HZ))
`define PG_PWM_MIN_HZ 1
// One PDM slot per fast clock at most; step register cannot hold 2^32
`define PG_PDM_MAX_HZ (`PG_CLK_HZ - 1)
`define PG_PDM_MIN_HZ 1525
`define PG_RATE_DEFAULT_HZ 32'h00004e20
// Phase step = rate * 2^32 / clock, done as (rate * mul) >> shift
`define PG_STEP_SHIFT 8
`define PG_STEP_MUL ((64'h1 << (32 + `PG_STEP_SHIFT)) / `PG_CLK_HZ)

// Reset values
`define PG_SCALE_ONE 32'h00010000
`define PG_FMT_DEFAULT 3'h1

// Byte offsets
`define PG_OFF_PWM_RATE 8'h00
`define PG_OFF_PDM_RATE 8'h04
`define PG_OFF_STATUS 8'h08
`define PG_OFF_INST_BASE 8'h10
// Word index within an instance block of four words
`define PG_IDX_CMD 2'h0
`define PG_IDX_SCALE 2'h1
`define PG_IDX_CTRL 2'h2

// Control word fields
`define PG_CTRL_EN_BIT 0
`define PG_CTRL_FMT_LSB 4
`define PG_CTRL_FMT_MSB 6

`endif

/* pwm_pdm_pkg.sv */
/*
 * Types of the multi-mode pulse generator.
 * Assumes pwm_pdm_params.svh for all numeric constants.
 */
package pwm_pdm_pkg;

    // Output format codes as written by software
    typedef enum logic [2:0] {
        FMT_PWM_DIR = 3'h1,
        FMT_UP_DOWN = 3'h2,
        FMT_PDM_DIR = 3'h3,
        FMT_DIR_PWM = 3'h4
    } out_format_t;

    // Per-instance settings
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] scale;
        logic [2:0] fmt;
        logic en;
    } inst_cfg_t;

    // Three drive lines of one instance
    typedef struct packed {
        logic drv_enable_n;
        logic first_signal_output;
        logic second_signal_output;
    } drive_pins_t;

endpackage

/* pwm_pdm_amp_model.sv */
/* Amplifier stand-in: counts high cycles per signal line and pulse starts per first signal line.
   Assumes registered pins on hclk; clr zeroes all counts. */
`timescale 1ns/1ps
`include "pwm_pdm_params.svh"
module pwm_pdm_amp_model
    import pwm_pdm_pkg::*;
(
    input wire logic hclk,
    input wire drive_pins_t [`PG_NUM_INST-1:0] pins,
    input wire logic clr,
    output int hi_cnt [`PG_NUM_INST*2],
    output int rise_cnt [`PG_NUM_INST]
);
    drive_pins_t [`PG_NUM_INST-1:0] pins_q;
    // Unknown levels add a large count so no window check can pass on them
    function automatic int lvl(input logic b);
        return (b === 1'b1) ? 1 : ((b === 1'b0) ? 0 : 100000);
    endfunction
    // Counts are not gated by the disable line, so stray pulses still show
    always @(posedge hclk) begin
        pins_q <= pins;
        for (int i = 0; i < `PG_NUM_INST; i++) begin
            if (clr) begin
                hi_cnt[2*i] <= 0;
                hi_cnt[2*i+1] <= 0;
                rise_cnt[i] <= 0;
            end else begin
                hi_cnt[2*i] <= hi_cnt[2*i] + lvl(pins[i].first_signal_output);
                hi_cnt[2*i+1] <= hi_cnt[2*i+1] + lvl(pins[i].second_signal_output);
                rise_cnt[i] <= rise_cnt[i] + int'(pins[i].first_signal_output & ~pins_q[i].first_signal_output);
            end
        end
    end
endmodule

/* pwm_pdm_gen_sva.sv */
/* Checker for pwm_pdm_gen, bound to its ports.
   Assumes single whole-word transfers and hready tied to hreadyout. */
`timescale 1ns/1ps
`include "pwm_pdm_params.svh"
module pwm_pdm_gen_sva
    import pwm_pdm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire drive_pins_t [`PG_NUM_INST-1:0] pins
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] a_q;
    logic w_q;
    logic [3:0] ix;
    logic [3:0] en_sh;
    logic [3:0][2:0] fmt_sh;
    assign ix = a_q[7:4] - 4'h1;
    // Shadow of control words, landing at the data-phase edge like the slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_q <= 8'h00;
            w_q <= 1'b0;
            en_sh <= 4'h0;
            fmt_sh <= {4{3'h1}};
        end else begin
            if (hready) begin
                a_q <= haddr;
                w_q <= hsel & htrans[1] & hwrite;
            end
            if (w_q && ix < 4'h4 && a_q[3:2] == 2'h2) begin
                en_sh[ix[1:0]] <= hwdata[0];
                fmt_sh[ix[1:0]] <= hwdata[6:4];
            end
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    a_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
        else $error("read data moved without a read");
    for (genvar i = 0; i < `PG_NUM_INST; i++) begin : g_inst
        a_off_idle: assert property (!en_sh[i] |=> pins[i] == 3'b100)
            else $error("disabled instance still drives");
        a_on_drive: assert property (en_sh[i] |=> !pins[i].drv_enable_n)
            else $error("enabled instance held off");
        a_bad_fmt: assert property (en_sh[i] && (fmt_sh[i] == 3'h0 || fmt_sh[i] > 3'h4) |=> pins[i] == 3'b000)
            else $error("unknown format drives outputs");
        a_updn_excl: assert property (en_sh[i] && fmt_sh[i] == FMT_UP_DOWN |=>
            !(pins[i].first_signal_output && pins[i].second_signal_output))
            else $error("up and down pulses together");
        a_dir_steady: assert property ((!w_q && en_sh[i] && (fmt_sh[i] == FMT_PWM_DIR || fmt_sh[i] == FMT_PDM_DIR)) [*2]
            |=> $stable(pins[i].second_signal_output))
            else $error("direction moved without a write");
    end
endmodule
bind pwm_pdm_gen pwm_pdm_gen_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins));

/* pwm_pdm_gen_tb.sv */
/* Self-checking bench for pwm_pdm_gen with an integer duty model.
   Assumes zero-wait-state answers and the amplifier model's counters. */
`timescale 1ns/1ps
`include "pwm_pdm_params.svh"
module pwm_pdm_gen_tb
    import pwm_pdm_pkg::*;
;
    localparam int W = 2000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic clr = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] q;
    drive_pins_t [`PG_NUM_INST-1:0] pins;
    int hi_cnt [`PG_NUM_INST*2];
    int rise_cnt [`PG_NUM_INST];
    int err_total = 0;
    int n_tests = 0;
    int c [`PG_NUM_INST];
    longint d;
    int e, f;
    always #2.5 hclk = ~hclk;
    pwm_pdm_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pins(pins));
    pwm_pdm_amp_model amp (.hclk(hclk), .pins(pins), .clr(clr), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic near(input string n, input int x, input int g, input int t);
        n_tests++;
        if (g < x - t || g > x + t) begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", n, x, g);
        end
    endtask
    // One single transfer; waits on hready rather than assuming a latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dw;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
        bus(1'b0, a, 32'h0);
        cmp(n, x, q);
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge hclk);
        err_total++;
        finish_test();
    end
    initial begin
        void'($urandom(34));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp("pins", {`PG_NUM_INST{3'b100}}, pins);
        rd(`PG_OFF_PWM_RATE, `PG_RATE_DEFAULT_HZ, "pwm_rate");
        rd(`PG_OFF_PDM_RATE, `PG_RATE_DEFAULT_HZ, "pdm_rate");
        for (int i = 0; i < `PG_NUM_INST; i++) rd(8'h14 + 8'(16 * i), `PG_SCALE_ONE, "scale");
        bus(1'b1, `PG_OFF_PWM_RATE, 32'hffffffff);
        rd(`PG_OFF_PWM_RATE, `PG_PWM_MAX_HZ, "pwm_rate");
        bus(1'b1, `PG_OFF_PWM_RATE, 32'h0);
        rd(`PG_OFF_PWM_RATE, `PG_PWM_MIN_HZ, "pwm_rate");
        bus(1'b1, `PG_OFF_PDM_RATE, 32'hffffffff);
        rd(`PG_OFF_PDM_RATE, `PG_PDM_MAX_HZ, "pdm_rate");
        bus(1'b1, `PG_OFF_PDM_RATE, 32'h5);
        rd(`PG_OFF_PDM_RATE, `PG_PDM_MIN_HZ, "pdm_rate");
        bus(1'b1, 8'h0c, 32'h5a5a5a5a);
        rd(8'h0c, 32'h0, "unmapped");
        bus(1'b1, `PG_OFF_PWM_RATE, 32'd200000);
        bus(1'b1, `PG_OFF_PDM_RATE, 32'd10000000);
        // Formats rotate across instances while enabled, so each runs every format
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < `PG_NUM_INST; i++) begin
                c[i] = (p == 2) ? ((i % 2) ? -196608 : 196608) : int'($urandom_range(120000)) - 60000;
                bus(1'b1, 8'h10 + 8'(16 * i), c[i]);
                bus(1'b1, 8'h14 + 8'(16 * i), (p == 3) ? 32'h20000 : `PG_SCALE_ONE);
                bus(1'b1, 8'h18 + 8'(16 * i), {25'h0, 3'((i + p) % 4 + 1), 4'h1});
            end
            clr <= 1'b1;
            @(posedge hclk);
            clr <= 1'b0;
            repeat (W) @(posedge hclk);
            for (int i = 0; i < `PG_NUM_INST; i++) begin
                f = (i + p) % 4 + 1;
                d = longint'(c[i] < 0 ? -c[i] : c[i]) * 65536 / ((p == 3) ? 131072 : 65536);
                e = int'((d > 65536 ? 65536 : d) * W / 65536);
                near("first_out", (f == 4) ? (c[i] < 0 ? W : 0) : (f == 2 && c[i] < 0) ? 0 : e,
                    hi_cnt[2*i], (f == 3) ? 50 : 8);
                near("second_out", (f == 2) ? (c[i] < 0 ? e : 0) : (f == 4) ? e : (c[i] < 0 ? W : 0),
                    hi_cnt[2*i+1], 8);
                if (f == 3) near("pdm_pulses", (e < W - e ? e : W - e) / 20, rise_cnt[i], 3);
            end
        end
        bus(1'b1, 8'h18, 32'h00000001);
        repeat (2) @(posedge hclk);
        cmp("bad_fmt", 32'h0, pins[0]);
        for (int i = 0; i < `PG_NUM_INST; i++) bus(1'b1, 8'h18 + 8'(16 * i), 32'h00000010);
        repeat (2) @(posedge hclk);
        rd(`PG_OFF_STATUS, {20'h0, {`PG_NUM_INST{3'b100}}}, "status");
        finish_test();
    end
endmodule
